// ==== grm_pkg.sv ====
/*
 Shared constants and types for the GMII reconciliation block.
 Assumes a single 40 MHz system clock that samples every GMII input pin.
*/
`default_nettype none
package grm_pkg;
   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned LPI_HOLD_S = 1;
   localparam int unsigned LPI_HOLD_CYC = LPI_HOLD_S * CLK_HZ;
   // Half period of the sourced transmit clock, in system cycles
   localparam int unsigned GTX_HALF = 4;
   localparam int unsigned GTX_HALF_W = 4;

   // ==========================================================
   // Transmit codes with enable low; error high for all but idle
   localparam logic [7:0] TXD_LPI = 8'h01;
   localparam logic [7:0] TXD_EXT = 8'h0F;
   localparam logic [7:0] TXD_EXT_ERR = 8'h1F;
   localparam logic [7:0] TXD_IDLE = 8'h00;
   localparam int unsigned UNITS_PER_OCTET = 8;
   localparam logic [3:0] UNIT_CNT_FULL = 4'h8;

   // ==========================================================
   // Bit-level units at the MAC side
   typedef enum logic [2:0] {
      TXU_ONE,
      TXU_ZERO,
      TXU_COMPLETE,
      TXU_EXTEND,
      TXU_EXTEND_ERROR
   } grm_tx_unit_e;

   typedef enum logic [1:0] {
      RXU_ONE,
      RXU_ZERO,
      RXU_EXTEND
   } grm_rx_unit_e;
endpackage : grm_pkg
`default_nettype wire

// ==== grm_oct_if.sv ====
/*
 Octet hand-off from the receive sampler to the bit-level unit generator.
 Assumes both ends run on the same system clock.
*/
`default_nettype none
interface grm_oct_if;
   logic [7:0] octet;
   logic is_ext;
   logic load;
   modport src (output octet, output is_ext, output load);
   modport dst (input octet, input is_ext, input load);
endinterface : grm_oct_if
`default_nettype wire

// ==== grm_rx_bits.sv ====
/*
 Splits each received octet into eight bit-level receive units, LSB first.
 Assumes octets arrive no faster than one per eight system cycles.
*/
`default_nettype none
module grm_rx_bits (
   input wire logic sys_clk,
   input wire logic srst,
   grm_oct_if.dst oct,
   output var grm_pkg::grm_rx_unit_e rx_unit,
   output logic rx_unit_valid
);
   logic [7:0] shreg;
   logic [3:0] left;
   logic ext;

   // ==========================================================
   // Octet store and countdown
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         shreg <= 8'h00;
         left <= 4'h0;
         ext <= 1'b0;
      end else if (oct.load) begin
         // A new octet restarts delivery
         shreg <= oct.octet;
         left <= grm_pkg::UNIT_CNT_FULL;
         ext <= oct.is_ext;
      end else if (left != 4'h0) begin
         shreg <= {1'b0, shreg[7:1]};
         left <= left - 4'h1;
      end
   end

   // ==========================================================
   // One unit per cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rx_unit <= grm_pkg::RXU_ZERO;
         rx_unit_valid <= 1'b0;
      end else begin
         rx_unit_valid <= (left != 4'h0);
         if (ext) begin
            rx_unit <= grm_pkg::RXU_EXTEND;
         end else if (shreg[0]) begin
            rx_unit <= grm_pkg::RXU_ONE;
         end else begin
            rx_unit <= grm_pkg::RXU_ZERO;
         end
      end
   end
endmodule : grm_rx_bits
`default_nettype wire

// ==== grm_top.sv ====
/*
 Reconciliation logic between a bit-level MAC service and an octet-wide
 GMII PHY: transmit mapping, sourced transmit clock, receive mapping,
 carrier, collision and data-valid indications, error forcing, LPI gating.
 Assumes all GMII inputs are asynchronous to sys_clk and the receive clock
 is slow enough to be sampled (at most an eighth of sys_clk).
*/
`default_nettype none

// What this block does
// - No LPI request unless link is OK
// - Hold off LPI one second after link OK
// - Carrier sense defers MAC during LPI
// - Five transmit unit values mapped to pins
// - Enable high: eight TXD lines carry data
// - Enable low, error high: extend codes
// - Complete shown by dropping enable/error
// - Pins update once per eight units
// - Block sources the transmit clock
// - Receive units ONE, ZERO, EXTEND derived
// - Each received octet gives eight units
// - Extension code reported as EXTEND
// - Carrier follows CRS, indicate changes
// - Signal error follows COL, indicate changes
// - Receive error forces frame check failure
// - Extend error delivers data, forces failure
// - Substitute data so CRC cannot pass
// - Error propagation: error with enable
// - Corrupted extension uses extend error code
// - Repeater may forward errors onto TX_ER
// - Data-valid status tracked, changes indicated
// - Outputs stable at transmit clock rise
// - Receive pins sampled at receive clock rise
// - 0F extend, 1F extend error codes
// - LPI request: enable low, error high, 01
module grm_top #(
   parameter int unsigned LPI_HOLD_CYC = grm_pkg::LPI_HOLD_CYC,
   parameter int unsigned GTX_HALF = grm_pkg::GTX_HALF
) (
   input wire logic sys_clk,
   input wire logic srst,
   // MAC transmit units
   input wire grm_pkg::grm_tx_unit_e tx_unit,
   input wire logic tx_unit_valid,
   output logic tx_unit_ready,
   input wire logic tx_err_prop,
   // MAC LPI control
   input wire logic lpi_req,
   input wire logic link_ok,
   output logic lpi_active,
   // MAC receive units and indications
   output var grm_pkg::grm_rx_unit_e rx_unit,
   output logic rx_unit_valid,
   output logic rx_fcs_fail,
   output logic carrier_on,
   output logic carrier_chg,
   output logic signal_err,
   output logic signal_chg,
   output logic data_valid,
   output logic data_valid_chg,
   // GMII transmit
   output logic gtx_clk,
   output logic [7:0] txd,
   output logic tx_en,
   output logic tx_er,
   // GMII receive
   input wire logic rx_clk,
   input wire logic [7:0] rxd,
   input wire logic rx_dv,
   input wire logic rx_er,
   input wire logic crs,
   input wire logic col
);
   localparam int CW = $clog2(LPI_HOLD_CYC + 1);
   localparam int PW = 14;

   // ==========================================================
   // Pin synchronisers
   logic [PW-1:0] pin_meta;
   logic [PW-1:0] pin_s;
   logic rxclk_prev;
   logic s_rxclk;
   logic s_dv;
   logic s_er;
   logic [7:0] s_rxd;
   logic s_crs;
   logic s_col;
   logic s_link;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_meta <= '0;
         pin_s <= '0;
         rxclk_prev <= 1'b0;
      end else begin
         pin_meta <= {link_ok, col, crs, rx_er, rx_dv, rxd, rx_clk};
         pin_s <= pin_meta;
         rxclk_prev <= s_rxclk;
      end
   end

   assign s_rxclk = pin_s[0];
   assign s_rxd = pin_s[8:1];
   assign s_dv = pin_s[9];
   assign s_er = pin_s[10];
   assign s_crs = pin_s[11];
   assign s_col = pin_s[12];
   assign s_link = pin_s[13];

   // ==========================================================
   // LPI gating
   // Counter restarts whenever the link drops, so the hold-off is
   // measured from the latest change to OK.
   logic [CW-1:0] hold_cnt;
   logic lpi_ok;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         hold_cnt <= '0;
      end else if (!s_link) begin
         hold_cnt <= '0;
      end else if (hold_cnt != CW'(LPI_HOLD_CYC)) begin
         hold_cnt <= hold_cnt + CW'(1);
      end
   end

   assign lpi_ok = s_link && (hold_cnt == CW'(LPI_HOLD_CYC));

   // ==========================================================
   // Sourced transmit clock
   logic [grm_pkg::GTX_HALF_W-1:0] div_cnt;
   logic div_wrap;
   logic gtx_fall;

   assign div_wrap = (div_cnt == grm_pkg::GTX_HALF_W'(GTX_HALF - 1));
   // Pins change as the clock falls, so they are settled at its rise
   assign gtx_fall = div_wrap && gtx_clk;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         div_cnt <= '0;
         gtx_clk <= 1'b0;
      end else if (div_wrap) begin
         div_cnt <= '0;
         gtx_clk <= !gtx_clk;
      end else begin
         div_cnt <= div_cnt + grm_pkg::GTX_HALF_W'(1);
      end
   end

   // ==========================================================
   // Transmit unit gathering
   logic [7:0] grp_bits;
   logic [3:0] grp_cnt;
   grm_pkg::grm_tx_unit_e grp_kind;
   logic grp_err;
   logic grp_full;
   logic take;

   assign grp_full = (grp_cnt == grm_pkg::UNIT_CNT_FULL);
   assign tx_unit_ready = !grp_full || gtx_fall;
   assign take = tx_unit_valid && tx_unit_ready;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         grp_bits <= 8'h00;
         grp_cnt <= 4'h0;
         grp_kind <= grm_pkg::TXU_COMPLETE;
         grp_err <= 1'b0;
      end else if (take) begin
         // Full group leaving now: this unit opens the next, no gap on the pins
         if (grp_cnt == 4'h0 || grp_full) begin
            grp_kind <= tx_unit;
         end
         grp_bits <= {tx_unit == grm_pkg::TXU_ONE, grp_bits[7:1]};
         grp_err <= (grp_err && !grp_full) || tx_err_prop;
         if (tx_unit == grm_pkg::TXU_COMPLETE) begin
            // A stop needs no further units
            grp_cnt <= grm_pkg::UNIT_CNT_FULL;
         end else begin
            grp_cnt <= grp_full ? 4'h1 : grp_cnt + 4'h1;
         end
      end else if (grp_full && gtx_fall) begin
         grp_cnt <= 4'h0;
         grp_err <= 1'b0;
      end
   end

   // ==========================================================
   // Transmit pin update
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         txd <= grm_pkg::TXD_IDLE;
         tx_en <= 1'b0;
         tx_er <= 1'b0;
         lpi_active <= 1'b0;
      end else if (gtx_fall) begin
         lpi_active <= 1'b0;
         if (grp_full) begin
            case (grp_kind)
               grm_pkg::TXU_ONE,
               grm_pkg::TXU_ZERO: begin
                  txd <= grp_bits;
                  tx_en <= 1'b1;
                  tx_er <= grp_err;
               end
               grm_pkg::TXU_EXTEND: begin
                  txd <= grm_pkg::TXD_EXT;
                  tx_en <= 1'b0;
                  tx_er <= 1'b1;
               end
               grm_pkg::TXU_EXTEND_ERROR: begin
                  txd <= grm_pkg::TXD_EXT_ERR;
                  tx_en <= 1'b0;
                  tx_er <= 1'b1;
               end
               default: begin
                  txd <= grm_pkg::TXD_IDLE;
                  tx_en <= 1'b0;
                  tx_er <= 1'b0;
               end
            endcase
         end else if (lpi_req && lpi_ok && grp_cnt == 4'h0) begin
            txd <= grm_pkg::TXD_LPI;
            tx_en <= 1'b0;
            tx_er <= 1'b1;
            lpi_active <= 1'b1;
         end else begin
            // Underrun or idle both end up as inter-frame
            txd <= grm_pkg::TXD_IDLE;
            tx_en <= 1'b0;
            tx_er <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Receive sampling
   grm_oct_if oct ();
   logic rx_rise;
   logic ext_code;
   logic ext_err_code;
   logic dv_now;
   logic bad_now;
   logic bad_frame;
   logic [7:0] rx_octet;
   logic rx_load;
   logic rx_is_ext;

   assign rx_rise = s_rxclk && !rxclk_prev;
   assign ext_code = !s_dv && s_er && (s_rxd == grm_pkg::TXD_EXT);
   assign ext_err_code = !s_dv && s_er && (s_rxd == grm_pkg::TXD_EXT_ERR);
   assign dv_now = s_dv || ext_code || ext_err_code;
   assign bad_now = (s_dv && s_er) || ext_err_code;

   // Set wins over the end-of-frame clear, so no error is lost
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bad_frame <= 1'b0;
      end else if (rx_rise) begin
         if (bad_now) begin
            bad_frame <= 1'b1;
         end else if (!dv_now) begin
            bad_frame <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rx_octet <= 8'h00;
         rx_load <= 1'b0;
         rx_is_ext <= 1'b0;
      end else begin
         rx_load <= rx_rise && dv_now;
         if (rx_rise) begin
            rx_is_ext <= ext_code;
            if (bad_now || bad_frame) begin
               // Inverted data spoils the CRC; the flag backs it up
               rx_octet <= ~s_rxd;
            end else begin
               rx_octet <= s_rxd;
            end
         end
      end
   end

   assign oct.octet = rx_octet;
   assign oct.is_ext = rx_is_ext;
   assign oct.load = rx_load;

   grm_rx_bits u_bits (
      .sys_clk(sys_clk),
      .srst(srst),
      .oct(oct.dst),
      .rx_unit(rx_unit),
      .rx_unit_valid(rx_unit_valid)
   );

   // ==========================================================
   // Status indications
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rx_fcs_fail <= 1'b0;
      end else if (rx_rise) begin
         rx_fcs_fail <= bad_now || (bad_frame && dv_now);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         carrier_on <= 1'b0;
         carrier_chg <= 1'b0;
      end else begin
         // LPI holds off the full-duplex MAC via carrier
         carrier_on <= s_crs || lpi_active;
         carrier_chg <= carrier_on != (s_crs || lpi_active);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         signal_err <= 1'b0;
         signal_chg <= 1'b0;
      end else begin
         signal_err <= s_col;
         signal_chg <= signal_err != s_col;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         data_valid <= 1'b0;
         data_valid_chg <= 1'b0;
      end else begin
         data_valid_chg <= 1'b0;
         if (rx_rise) begin
            data_valid <= dv_now;
            data_valid_chg <= data_valid != dv_now;
         end
      end
   end
endmodule : grm_top
`default_nettype wire

// ==== grm_props.sv ====
/*
 Checker for the GMII reconciliation top ports.
 Assumes GTX_HALF is 4 and one sys_clk domain.
*/
`default_nettype none
module grm_props #(
   parameter int unsigned LPI_HOLD_CYC = 50
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic link_ok,
   input wire logic lpi_active,
   input wire logic gtx_clk,
   input wire logic [7:0] txd,
   input wire logic tx_en,
   input wire logic tx_er,
   input wire logic crs,
   input wire logic carrier_on,
   input wire logic carrier_chg,
   input wire logic signal_err,
   input wire logic signal_chg,
   input wire logic data_valid,
   input wire logic data_valid_chg,
   input wire logic rx_unit_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // ====================
   // Link run lengths at the pin; pin leads the synced copy
   int unsigned up_cnt;
   int unsigned dn_cnt;
   always_ff @(posedge sys_clk) begin
      up_cnt <= (srst || !link_ok) ? 0 : up_cnt + 1;
      dn_cnt <= (srst || link_ok) ? 0 : dn_cnt + 1;
   end
   property p_lpi_hold;
      $rose(lpi_active) |-> up_cnt >= LPI_HOLD_CYC;
   endproperty
   a_lpi_hold: assert property (p_lpi_hold) else $error("lpi too early");
   // Sync plus one transmit period at most
   property p_lpi_off;
      dn_cnt >= 16 |-> !lpi_active;
   endproperty
   a_lpi_off: assert property (p_lpi_off) else $error("lpi without link");
   property p_lpi_code;
      lpi_active |-> !tx_en && tx_er && txd == 8'h01;
   endproperty
   a_lpi_code: assert property (p_lpi_code) else $error("lpi code wrong");
   property p_pin_edge;
      !$stable({txd, tx_en, tx_er}) |-> $fell(gtx_clk);
   endproperty
   a_pin_edge: assert property (p_pin_edge) else $error("pins off edge");
   property p_gtx;
      $rose(gtx_clk) |-> gtx_clk [*4] ##1 !gtx_clk;
   endproperty
   a_gtx: assert property (p_gtx) else $error("gtx high time");
   property p_ext_code;
      tx_er && !tx_en |-> txd inside {8'h01, 8'h0F, 8'h1F};
   endproperty
   a_ext_code: assert property (p_ext_code) else $error("bad code");
   property p_car_chg;
      carrier_chg == (carrier_on != $past(carrier_on));
   endproperty
   a_car_chg: assert property (p_car_chg) else $error("carrier pulse");
   property p_sig_chg;
      signal_chg == (signal_err != $past(signal_err));
   endproperty
   a_sig_chg: assert property (p_sig_chg) else $error("signal pulse");
   property p_dv_chg;
      data_valid_chg == (data_valid != $past(data_valid));
   endproperty
   a_dv_chg: assert property (p_dv_chg) else $error("valid pulse");
   property p_crs;
      crs [*6] |-> carrier_on;
   endproperty
   a_crs: assert property (p_crs) else $error("carrier lost");
   property p_units;
      $rose(rx_unit_valid) |-> rx_unit_valid [*8];
   endproperty
   a_units: assert property (p_units) else $error("short burst");
   c_lpi: cover property ($rose(lpi_active));
   c_units: cover property ($rose(rx_unit_valid));
   c_ext: cover property (tx_er && !tx_en && txd == 8'h0F);
endmodule : grm_props
bind grm_top grm_props #(.LPI_HOLD_CYC(LPI_HOLD_CYC)) u_grm_props (.sys_clk, .srst,
   .link_ok, .lpi_active, .gtx_clk, .txd, .tx_en, .tx_er, .crs, .carrier_on,
   .carrier_chg, .signal_err, .signal_chg, .data_valid, .data_valid_chg,
   .rx_unit_valid);
`default_nettype wire

// ==== grm_phy.sv ====
/*
 PHY model: free receive clock, octet sender, transmit capture.
 Assumes the bench calls send from one process.
*/
`default_nettype none
module grm_phy (
   input wire logic gtx_clk,
   input wire logic [7:0] txd,
   input wire logic tx_en,
   input wire logic tx_er,
   output logic rx_clk,
   output logic [7:0] rxd,
   output logic rx_dv,
   output logic rx_er,
   output logic crs
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] txq[$];
   logic [9:0] last_tx = 10'h000;
   // ====================
   // Odd offset keeps phase unrelated to sys_clk
   initial begin
      rx_clk = 1'b0;
      {rxd, rx_dv, rx_er, crs} = 11'h000;
      #37;
      forever #100 rx_clk = ~rx_clk;
   end
   task automatic send(input logic dv, input logic er, input logic [7:0] d);
      @(negedge rx_clk);
      rx_dv = dv;
      rx_er = er;
      crs = dv | er;
      // Released lines must not look like the last octet
      rxd = (dv | er) ? d : ~rxd;
   endtask : send
   // An idle beat is kept only where it ends a transmission or follows an LPI beat
   always @(posedge gtx_clk) begin
      if ((tx_en | tx_er | last_tx[9] | last_tx[8]) && !(!tx_en && tx_er && txd == 8'h01))
         txq.push_back({tx_en, tx_er, txd});
      last_tx = {tx_en, tx_er, txd};
   end
endmodule : grm_phy
`default_nettype wire

// ==== gmii_reconciliation_mapping_test.sv ====
/*
 Self-checking bench for grm_top with the PHY model.
 Assumes grm_props is bound to grm_top.
*/
`default_nettype none
module gmii_reconciliation_mapping_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned HOLD = 50;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   grm_pkg::grm_tx_unit_e tx_unit = grm_pkg::TXU_ZERO;
   logic tx_unit_valid = 1'b0, tx_err_prop = 1'b0, lpi_req = 1'b0;
   logic link_ok = 1'b0, col = 1'b0;
   logic tx_unit_ready, lpi_active, rx_unit_valid, rx_fcs_fail, carrier_on;
   logic carrier_chg, signal_err, signal_chg, data_valid, data_valid_chg;
   logic gtx_clk, tx_en, tx_er, rx_clk, rx_dv, rx_er, crs;
   logic [7:0] txd, rxd;
   logic fcs_seen = 1'b0;
   int n_unit = 0;
   grm_pkg::grm_rx_unit_e rx_unit;
   logic [9:0] exq[$];
   logic [2:0] rxq[$], erq[$];
   logic bad = 1'b0;
   int bad_count = 0, samples_checked = 0, n_car = 0, n_sig = 0, n_dv = 0;
   grm_top #(.LPI_HOLD_CYC(HOLD), .GTX_HALF(4)) u_grm_top (.sys_clk, .srst,
      .tx_unit, .tx_unit_valid, .tx_unit_ready, .tx_err_prop, .lpi_req, .link_ok,
      .lpi_active, .rx_unit, .rx_unit_valid, .rx_fcs_fail, .carrier_on,
      .carrier_chg, .signal_err, .signal_chg, .data_valid, .data_valid_chg,
      .gtx_clk, .txd, .tx_en, .tx_er, .rx_clk, .rxd, .rx_dv, .rx_er, .crs, .col);
   grm_phy u_grm_phy (.gtx_clk, .txd, .tx_en, .tx_er, .rx_clk, .rxd, .rx_dv,
      .rx_er, .crs);
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      // The flag stands one receive sample, so take it at an octet's first unit
      if (rx_unit_valid === 1'b1) begin
         if (n_unit % 8 == 0)
            fcs_seen = rx_fcs_fail;
         rxq.push_back({fcs_seen, rx_unit});
         n_unit++;
      end
      n_car += int'(carrier_chg === 1'b1);
      n_sig += int'(signal_chg === 1'b1);
      n_dv += int'(data_valid_chg === 1'b1);
   end
   // ====================
   // Checking and closing
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : wait_cyc
   // ====================
   // Transmit units, one sys cycle each when ready
   function automatic grm_pkg::grm_tx_unit_e tu(input int k, input logic b);
      case (k)
         0: return b ? grm_pkg::TXU_ONE : grm_pkg::TXU_ZERO;
         1: return grm_pkg::TXU_EXTEND;
         default: return grm_pkg::TXU_EXTEND_ERROR;
      endcase
   endfunction : tu
   task automatic put(input grm_pkg::grm_tx_unit_e u, input logic e);
      logic r;
      #2;
      tx_unit = u;
      tx_err_prop = e;
      tx_unit_valid = 1'b1;
      do begin
         @(negedge sys_clk);
         r = tx_unit_ready;
         @(posedge sys_clk);
      end while (r !== 1'b1);
   endtask : put
   task automatic grp(input int k, input logic [7:0] v, input logic e);
      for (int i = 0; i < 8; i++)
         put(tu(k, v[i]), e);
      exq.push_back(k == 0 ? {1'b1, e, v} : {2'b01, k == 1 ? 8'h0F : 8'h1F});
   endtask : grp
   // Expected units follow the frame-bad state of the stream
   task automatic rx(input logic dv, input logic er, input logic [7:0] v);
      logic ext;
      ext = !dv && er && (v == 8'h0F || v == 8'h1F);
      u_grm_phy.send(dv, er, v);
      if (dv && er || ext && v == 8'h1F)
         bad = 1'b1;
      if (!dv && !ext)
         bad = 1'b0;
      if (bad)
         v = ~v;
      for (int i = 0; i < 8 && (dv || ext); i++)
         erq.push_back(ext && !bad ? {1'b0, grm_pkg::RXU_EXTEND}
            : {bad, v[i] ? grm_pkg::RXU_ONE : grm_pkg::RXU_ZERO});
   endtask : rx
   initial begin
      #500000;
      bad_count++;
      results();
   end
   initial begin
      void'($urandom(32'hAA5D));
      wait_cyc(8);
      srst = 1'b0;
      for (int n = 0; n < 10; n++)
         grp(0, n == 0 ? 8'h00 : n == 1 ? 8'hFF : 8'($urandom), $urandom_range(3) == 0);
      grp(1, 8'h00, 1'b0);
      grp(2, 8'h00, 1'b0);
      put(grm_pkg::TXU_COMPLETE, 1'b0);
      exq.push_back(10'h000);
      #2;
      tx_unit_valid = 1'b0;
      wait_cyc(40);
      chk(16'(u_grm_phy.txq.size()), 16'(exq.size()));
      foreach (exq[i])
         chk(16'(u_grm_phy.txq[i]), 16'(exq[i]));
      chk(16'({tx_en, tx_er}), 16'h0000);
      for (int f = 0; f < 3; f++) begin
         rx(0, 0, 8'h00);
         rx(1, 0, 8'h55);
         rx(1, f == 1, 8'($urandom));
         rx(f == 1, f != 1, f == 1 ? 8'($urandom) : 8'h0F);
         if (f == 2)
            rx(0, 1, 8'h1F);
         rx(0, 0, 8'h00);
      end
      wait_cyc(40);
      chk(16'(rxq.size()), 16'(erq.size()));
      foreach (erq[i])
         chk(16'(rxq[i]), 16'(erq[i]));
      chk(16'(n_car), 16'h0006);
      chk(16'(n_dv), 16'h0006);
      for (int i = 0; i < 4; i++) begin
         col = !col;
         wait_cyc(10);
         chk(16'(signal_err), 16'(col));
      end
      chk(16'(n_sig), 16'h0004);
      lpi_req = 1'b1;
      wait_cyc(60);
      chk(16'(lpi_active), 16'h0000);
      link_ok = 1'b1;
      wait_cyc(HOLD - 10);
      chk(16'(lpi_active), 16'h0000);
      wait_cyc(40);
      chk(16'({lpi_active, carrier_on, u_grm_phy.last_tx}), 16'h0D01);
      link_ok = 1'b0;
      wait_cyc(30);
      chk(16'(lpi_active), 16'h0000);
      results();
   end
endmodule : gmii_reconciliation_mapping_test
`default_nettype wire
